// ===== hw/ssefe_map.vh
`ifndef SSEFE_MAP_VH
`define SSEFE_MAP_VH
// opcodes
`define SSEFE_OP_SET_LATCH   8'h06
`define SSEFE_OP_CLR_LATCH   8'h04
`define SSEFE_OP_STAT_READ   8'h05
`define SSEFE_OP_STAT_WRITE  8'h01
`define SSEFE_OP_ARRAY_READ  8'h03
`define SSEFE_OP_ARRAY_WRITE 8'h02
// status field positions
`define SSEFE_ST_BUSY        0
`define SSEFE_ST_LATCH       1
`define SSEFE_ST_BP0         2
`define SSEFE_ST_BP1         3
`define SSEFE_ST_PROT_EN     7
`define SSEFE_ST_WR_MASK     8'h8c
`define SSEFE_ST_RESET       8'h00
// timing
`define SSEFE_CLK_NS         100
`define SSEFE_PROG_MS        5
`define SSEFE_PROG_CYC       ((`SSEFE_PROG_MS * 1000000) / `SSEFE_CLK_NS)
`define SSEFE_PUP_MS         1
`define SSEFE_PUP_CYC        ((`SSEFE_PUP_MS * 1000000) / `SSEFE_CLK_NS)
`endif

// ===== hw/ssefe_top.v
`timescale 1ns/100ps
`include "ssefe_map.vh"

module ssefe_top #(
  parameter PROG_CYCLES = `SSEFE_PROG_CYC,
  parameter ADDR_BITS   = 13
) (
  input  wire                 clk,
  input  wire                 arst_n,
  // serial link
  input  wire                 sel_n,
  input  wire                 sclk,
  input  wire                 sdi,
  input  wire                 hold_n,
  input  wire                 protect_pin_n,
  output reg                  sdo_o,
  output reg                  sdo_oe_n,
  // memory side
  output reg                  mem_rd_q,
  output reg                  mem_wr_q,
  output reg  [ADDR_BITS-1:0] mem_addr_q,
  output reg  [7:0]           mem_wdata_q,
  input  wire [7:0]           mem_rdata,
  // status
  output reg  [7:0]           status_q,
  output reg                  ready_q
);
  localparam ST_CMD  = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_RDAT = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_SOUT = 3'd4;
  localparam ST_SWR  = 3'd5;
  localparam ST_IDLE = 3'd6;

  reg [1:0]           sel_s;
  reg [1:0]           sclk_s;
  reg [1:0]           sdi_s;
  reg [1:0]           hold_s;
  reg [1:0]           prot_s;
  reg                 sclk_q;
  reg [2:0]           state_q;
  reg [7:0]           shift_q;
  reg [3:0]           bits_q;
  reg [15:0]          addr_q;
  reg                 abyte_q;
  reg [7:0]           out_q;
  reg                 wr_pend_q;
  reg                 swr_pend_q;
  reg [7:0]           swr_val_q;
  reg [31:0]          prog_q;
  reg [31:0]          pup_q;
  reg                 rd_cmd_q;

  wire                sel_act = ~sel_s[1];
  wire                holding = ~hold_s[1];
  wire                rise    = sclk_s[1] & ~sclk_q;
  wire                fall    = ~sclk_s[1] & sclk_q;
  wire                busy    = status_q[`SSEFE_ST_BUSY];
  wire [7:0]          byte_in = {shift_q[6:0], sdi_s[1]};
  wire                last    = (bits_q == 4'd7);
  wire                sr_lock = ~prot_s[1] & status_q[`SSEFE_ST_PROT_EN];
  reg                 sel_q;

  // two-stage synchronisers for all link pins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_s  <= 2'b11;
      sclk_s <= 2'b00;
      sdi_s  <= 2'b00;
      hold_s <= 2'b11;
      prot_s <= 2'b11;
      sclk_q <= 1'b0;
      sel_q  <= 1'b0;
    end else begin
      sel_s  <= {sel_s[0], sel_n};
      sclk_s <= {sclk_s[0], sclk};
      sdi_s  <= {sdi_s[0], sdi};
      hold_s <= {hold_s[0], hold_n};
      prot_s <= {prot_s[0], protect_pin_n};
      sclk_q <= sclk_s[1];
      sel_q  <= sel_act;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      shift_q     <= 8'h00;
      bits_q      <= 4'd0;
      addr_q      <= 16'h0000;
      abyte_q     <= 1'b0;
      out_q       <= 8'h00;
      wr_pend_q   <= 1'b0;
      swr_pend_q  <= 1'b0;
      swr_val_q   <= 8'h00;
      prog_q      <= 32'd0;
      pup_q       <= 32'd0;
      rd_cmd_q    <= 1'b0;
      status_q    <= `SSEFE_ST_RESET;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= {ADDR_BITS{1'b0}};
      mem_wdata_q <= 8'h00;
      sdo_o       <= 1'b0;
      sdo_oe_n    <= 1'b1;
      ready_q     <= 1'b0;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      if (pup_q < `SSEFE_PUP_CYC)
        pup_q <= pup_q + 32'd1;
      else
        ready_q <= 1'b1;
      // programming runs on regardless of select
      if (busy) begin
        if (prog_q == PROG_CYCLES - 1) begin
          status_q[`SSEFE_ST_BUSY]  <= 1'b0;
          status_q[`SSEFE_ST_LATCH] <= 1'b0;
          prog_q <= 32'd0;
        end else
          prog_q <= prog_q + 32'd1;
      end
      if (!sel_act) begin
        sdo_oe_n <= 1'b1;
        state_q  <= ST_IDLE;
        if (sel_q && (wr_pend_q || swr_pend_q)) begin
          status_q[`SSEFE_ST_BUSY] <= 1'b1;
          if (swr_pend_q)
            status_q <= (status_q & ~`SSEFE_ST_WR_MASK) | (swr_val_q & `SSEFE_ST_WR_MASK)
                        | 8'h01;
          if (wr_pend_q)
            mem_wr_q <= 1'b1;
        end
        wr_pend_q  <= 1'b0;
        swr_pend_q <= 1'b0;
      end else if (!sel_q) begin
        state_q <= ST_CMD;
        bits_q  <= 4'd0;
        abyte_q <= 1'b0;
      end else if (holding) begin
        sdo_oe_n <= 1'b1;
      end else begin
        if (state_q == ST_RDAT || state_q == ST_SOUT)
          sdo_oe_n <= 1'b0;
        if (rise) begin
          shift_q <= byte_in;
          bits_q  <= last ? 4'd0 : bits_q + 4'd1;
          case (state_q)
            ST_CMD: if (last) begin
              if (busy)
                state_q <= (byte_in == `SSEFE_OP_STAT_READ) ? ST_SOUT : ST_IDLE;
              else case (byte_in)
                `SSEFE_OP_SET_LATCH: begin
                  status_q[`SSEFE_ST_LATCH] <= 1'b1;
                  state_q <= ST_IDLE;
                end
                `SSEFE_OP_CLR_LATCH: begin
                  status_q[`SSEFE_ST_LATCH] <= 1'b0;
                  state_q <= ST_IDLE;
                end
                `SSEFE_OP_STAT_READ:   state_q <= ST_SOUT;
                `SSEFE_OP_STAT_WRITE:  state_q <= ST_SWR;
                // opcode kept apart: the shifter is reused for the address
                `SSEFE_OP_ARRAY_READ: begin
                  rd_cmd_q <= 1'b1;
                  state_q  <= ST_ADDR;
                end
                `SSEFE_OP_ARRAY_WRITE: begin
                  rd_cmd_q <= 1'b0;
                  state_q  <= ST_ADDR;
                end
                default:               state_q <= ST_IDLE;
              endcase
              out_q  <= status_q;
              shift_q <= byte_in;
            end
            ST_ADDR: if (last) begin
              if (abyte_q) begin
                addr_q <= {addr_q[15:8], byte_in};
                mem_addr_q <= {addr_q[ADDR_BITS-1:8], byte_in};
                if (rd_cmd_q) begin
                  mem_rd_q <= 1'b1;
                  state_q  <= ST_RDAT;
                end else
                  state_q  <= ST_WDAT;
              end else begin
                addr_q[15:8] <= byte_in;
                abyte_q <= 1'b1;
              end
            end
            ST_WDAT: if (last) begin
              mem_wdata_q <= byte_in;
              wr_pend_q   <= status_q[`SSEFE_ST_LATCH];
            end
            ST_SWR: if (last) begin
              swr_val_q  <= byte_in;
              swr_pend_q <= status_q[`SSEFE_ST_LATCH] & ~sr_lock;
            end
            ST_RDAT: if (last) begin
              mem_addr_q <= mem_addr_q + {{(ADDR_BITS-1){1'b0}}, 1'b1};
              mem_rd_q   <= 1'b1;
            end
            default: ;
          endcase
        end
        if (fall) begin
          if (state_q == ST_SOUT || state_q == ST_RDAT) begin
            sdo_o <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
          end
        end
        if (mem_rd_q)
          out_q <= mem_rdata;
        // fresh status at each byte end, so a polling read sees busy drop
        if (state_q == ST_SOUT && last && rise)
          out_q <= status_q;
      end
    end
  end
endmodule

// ===== tb/ssefe_assertions.sv
`timescale 1ns/100ps
module ssefe_checker #(
  parameter PROG_CYCLES = 20,
  parameter ADDR_BITS   = 13
) (
  input wire                 clk,
  input wire                 arst_n,
  input wire                 sel_n,
  input wire                 sclk,
  input wire                 sdi,
  input wire                 hold_n,
  input wire                 protect_pin_n,
  input wire                 sdo_o,
  input wire                 sdo_oe_n,
  input wire                 mem_rd_q,
  input wire                 mem_wr_q,
  input wire [ADDR_BITS-1:0] mem_addr_q,
  input wire [7:0]           mem_wdata_q,
  input wire [7:0]           mem_rdata,
  input wire [7:0]           status_q,
  input wire                 ready_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  idle_off_a: assert property (sel_n [*5] |-> sdo_oe_n) else $error("output on while idle");
  wr_pulse_a: assert property (mem_wr_q |=> !mem_wr_q) else $error("write pulse too long");
  wr_at_rise_a: assert property (mem_wr_q |-> sel_n) else $error("write before select rise");
  wr_gate_a: assert property (mem_wr_q |-> status_q[1]) else $error("write without latch");
  busy_span_a: assert property ($rose(mem_wr_q) |-> ##[0:2] status_q[0] [*8] ##[1:500] !status_q[0])
    else $error("busy span wrong");
  busy_quiet_a: assert property (status_q[0] && $past(status_q[0]) |-> !mem_wr_q && !mem_rd_q)
    else $error("access while busy");
  out_hold_a: assert property ($rose(sclk) && !sdo_oe_n |=> $stable(sdo_o) [*2]) else $error("data moved");
  pin_lock_a: assert property (!protect_pin_n && status_q[7] |=> status_q[7] && $stable(status_q[3:2]))
    else $error("status changed while locked");
  cover property ($rose(status_q[0]));
  cover property (mem_rd_q);
  cover property (!hold_n && !sel_n);
endmodule
bind ssefe_top ssefe_checker #(.PROG_CYCLES(PROG_CYCLES), .ADDR_BITS(ADDR_BITS)) ssefe_checker_i (.*);

// ===== tb/ssefe_host.sv
`timescale 1ns/100ps
module ssefe_host (
  input  wire clk,
  input  wire sdo,
  input  wire sdo_oe_n,
  output reg  sel_n = 1'b1,
  output reg  sclk = 1'b0,
  output reg  sdi = 1'b0,
  output reg  hold_n = 1'b1
);
  // m picks the clock idle level, hp pauses mid-frame
  task automatic frame(input [31:0] tx, input int n, input m, input hp, output [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge clk) sclk <= m;
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      sdi <= tx[i];
      if (hp && i == n - 12) begin
        // pause only once the clock already stands low
        @(posedge clk) hold_n <= 1'b0;
        repeat (8) @(posedge clk) sdi <= ~sdi;
        @(posedge clk) hold_n <= 1'b1;
        sdi <= tx[i];
      end
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      @(posedge clk) rx = {rx[30:0], sdo_oe_n ? 1'bx : sdo};
      repeat (2) @(posedge clk);
    end
    @(posedge clk) sclk <= m;
    repeat (2) @(posedge clk);
    sel_n <= 1'b1;
    sdi <= ~sdi;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ===== tb/test_ssefe_top.sv
`timescale 1ns/100ps
module test_ssefe_top;
  reg        clk = 1'b0;
  reg        arst_n = 1'b0;
  reg        protect_pin_n = 1'b1;
  reg [31:0] rx;
  wire       sel_n, sclk, sdi, hold_n, sdo_o, sdo_oe_n, mem_rd_q, mem_wr_q, ready_q;
  wire [12:0] mem_addr_q;
  wire [7:0] mem_wdata_q, status_q;
  wire [7:0] mem_rdata = mem_addr_q[7:0] ^ 8'h5a;
  int        fail_count = 0;
  int        total_checks = 0;
  int        wr_seen = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) wr_seen += (mem_wr_q === 1'b1);
  ssefe_top #(.PROG_CYCLES(400)) ssefe_top_i (.clk(clk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk),
    .sdi(sdi), .hold_n(hold_n), .protect_pin_n(protect_pin_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .status_q(status_q), .ready_q(ready_q));
  ssefe_host ssefe_host_i (.clk(clk), .sdo(sdo_o), .sdo_oe_n(sdo_oe_n), .sel_n(sel_n), .sclk(sclk),
    .sdi(sdi), .hold_n(hold_n));
  task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0s: expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task idle;
    for (int k = 0; k < 600 && status_q[0] !== 1'b0; k++) @(posedge clk);
  endtask
  initial begin
    #3_000_000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    chk(0, ready_q, "ready");
    for (int k = 0; k < 11000 && ready_q !== 1'b1; k++) @(posedge clk);
    chk(1, ready_q, "ready");
    ssefe_host_i.frame(32'h0000_00ff, 8, 0, 0, rx);
    ssefe_host_i.frame(32'h0000_0500, 16, 0, 0, rx);
    chk(8'h00, rx[7:0], "status");
    ssefe_host_i.frame(32'h0000_0006, 8, 1, 0, rx);
    ssefe_host_i.frame(32'h0000_0500, 16, 1, 0, rx);
    chk(8'h02, rx[7:0], "status");
    ssefe_host_i.frame(32'h0000_0004, 8, 0, 0, rx);
    ssefe_host_i.frame(32'h0000_0500, 16, 1, 0, rx);
    chk(8'h00, rx[7:0], "status");
    ssefe_host_i.frame(32'h02e1_23c3, 32, 0, 0, rx);
    chk(0, wr_seen, "write");
    ssefe_host_i.frame(32'h0000_0006, 8, 0, 0, rx);
    ssefe_host_i.frame(32'h02e1_23c3, 32, 0, 1, rx);
    chk(1, wr_seen, "write");
    chk(13'h0123, mem_addr_q, "addr");
    chk(8'hc3, mem_wdata_q, "wdata");
    ssefe_host_i.frame(32'h0000_0500, 16, 0, 0, rx);
    chk(1, rx[0], "busy");
    ssefe_host_i.frame(32'h0000_018c, 16, 0, 0, rx);
    idle;
    chk(8'h00, status_q, "status");
    ssefe_host_i.frame(32'h0000_0006, 8, 0, 0, rx);
    ssefe_host_i.frame(32'h0000_018c, 16, 0, 0, rx);
    idle;
    chk(8'h8c, status_q, "status");
    protect_pin_n <= 1'b0;
    ssefe_host_i.frame(32'h0000_0006, 8, 0, 0, rx);
    ssefe_host_i.frame(32'h0000_0100, 16, 0, 0, rx);
    idle;
    chk(8'h8e, status_q, "status");
    ssefe_host_i.frame(32'h03e1_2300, 32, 1, 0, rx);
    chk(8'h79, rx[7:0], "rdata");
    chk(1, sdo_oe_n, "oe");
    wrap_up;
  end
endmodule
